// [rtl/panel_defs.svh]
// Constants for the front-panel indicator controller: timing, register map, fields.
// Assumes a 20 MHz system clock; all times are converted to cycles in the module.
`ifndef PANEL_DEFS_SVH
`define PANEL_DEFS_SVH

`define CLK_KHZ 20000
`define LAMP_MS 1000
`define LINK_AT_MS 3000
`define LINK_LEN_MS 500
`define FAIL_MS 1000
`define BLINK_HALF_MS 250

`define REG_CTRL 8'h00
`define REG_BLINK 8'h04
`define REG_IRQ_ST 8'h08
`define REG_IRQ_MASK 8'h0c
`define REG_STATE 8'h10
`define REG_MON 8'h14

`define CTRL_STAT_BLINK 0
`define CTRL_SOFT_RST 1
`define CTRL_RST_VAL 1'b0

`define IRQ_READY 0
`define IRQ_FAIL 1
`define IRQ_HOT 2
`define IRQ_SEL 3
`define NUM_IRQ 4
`define IRQ_MASK_RST 4'h0

`define NUM_SEG 5

`endif

// [rtl/panel_pkg.sv]
// Types shared by the front-panel indicator controller.
// Assumes panel_defs.svh supplies the numeric constants.
package panel_pkg;
    typedef enum logic [2:0] {ST_OFF, ST_LAMP, ST_DIAG, ST_RUN, ST_FAIL} phase_e;
    typedef enum logic [2:0] {SEG_TX, SEG_RX, SEG_ACT, SEG_COL, SEG_USR} seg_e;
endpackage

// [rtl/front_panel_status_leds.sv]
// Front-panel indicator controller: lamp sequence, diagnostic display, per-port LEDs.
// Assumes AHB-Lite single-word access, system status inputs on this clock,
// buttons and power-good arriving asynchronously from pins.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "panel_defs.svh"

// Functional notes
// R1: Lamp phase lights all indicators but port links for one second, then clears.
// R2: Power indicator lit while supply good, dark without power.
// R3: Ready blinks during diagnostics, steady after pass, dark when non-operational.
// R4: Some seconds into diagnostics all link indicators flash briefly, then show links.
// R5: Critical diagnostic failure darkens ready, then reboots into the lamp sequence.
// R6: Each link indicator follows its port's link state.
// R7: Monitored ports show the selected condition on or blinking; others stay dark.
// R8: Select press cycles TX, RX, Act, Col, Usr; exactly that segment LED lit.
// R9: Conditions: transmit, receive, either, collision, errors; same for all ports.
// R10: Power-up, reset button, soft reset and auto reset restart the sequence.
// R11: Overheat after diagnostics keeps the ready indicator blinking.
// R12: Blink timing from a programmable clock divider, default about half a second.
module front_panel_status_leds #(
    parameter int NPORTS = 24,
    parameter int unsigned LAMP_CYCLES = `LAMP_MS * `CLK_KHZ,
    parameter int unsigned LINK_AT_CYCLES = `LINK_AT_MS * `CLK_KHZ,
    parameter int unsigned LINK_LEN_CYCLES = `LINK_LEN_MS * `CLK_KHZ,
    parameter int unsigned FAIL_CYCLES = `FAIL_MS * `CLK_KHZ,
    parameter logic [31:0] BLINK_HALF_DEF = 32'(`BLINK_HALF_MS * `CLK_KHZ)
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic power_good,
    input wire logic reset_button,
    input wire logic select_button,
    input wire logic soft_reset_req,
    input wire logic auto_reset_req,
    input wire logic diag_pass,
    input wire logic diag_fail,
    input wire logic overheat,
    input wire logic [NPORTS-1:0] link_up,
    input wire logic [NPORTS-1:0] tx_act,
    input wire logic [NPORTS-1:0] rx_act,
    input wire logic [NPORTS-1:0] collision,
    input wire logic [NPORTS-1:0] rxtx_error,
    output logic pwr_led,
    output logic ready_led,
    output logic [NPORTS-1:0] link_led,
    output logic [NPORTS-1:0] status_led,
    output logic [`NUM_SEG-1:0] seg_led,
    output logic restart_pulse,
    output logic irq
);
    import panel_pkg::*;

    typedef struct packed {
        phase_e st;
        seg_e seg;
        logic [31:0] cnt;
        logic [31:0] bcnt;
        logic blink;
        logic [31:0] half;
        logic stat_blink;
        logic [NPORTS-1:0] mon;
        logic [`NUM_IRQ-1:0] irq_st;
        logic [`NUM_IRQ-1:0] irq_mask;
        logic pg_m;
        logic pg_s;
        logic rb_m;
        logic rb_s;
        logic rb_q;
        logic sb_m;
        logic sb_s;
        logic sb_q;
        logic hot_q;
        logic a_valid;
        logic a_wr;
        logic [7:0] a_addr;
        logic [31:0] rdata;
        logic pwr;
        logic ready;
        logic [NPORTS-1:0] link;
        logic [NPORTS-1:0] stat;
        logic [`NUM_SEG-1:0] segl;
        logic restart;
        logic irq;
    } panel_s;

    panel_s s_ff;
    panel_s nxt_s;

    logic take;
    logic wr_now;
    logic rst_press;
    logic sel_press;
    logic soft_wr;
    logic restart_evt;
    logic tick;
    logic link_win;
    logic link_after;
    logic [NPORTS-1:0] cond;
    logic [`NUM_IRQ-1:0] ev;
    logic [`NUM_IRQ-1:0] clr;
    logic [31:0] rd;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_ff.rdata;
    assign pwr_led = s_ff.pwr;
    assign ready_led = s_ff.ready;
    assign link_led = s_ff.link;
    assign status_led = s_ff.stat;
    assign seg_led = s_ff.segl;
    assign restart_pulse = s_ff.restart;
    assign irq = s_ff.irq;

    always_comb begin
        nxt_s = s_ff;
        // Pins pass two flops; first stage is read only by the second
        nxt_s.pg_m = power_good;
        nxt_s.pg_s = s_ff.pg_m;
        nxt_s.rb_m = reset_button;
        nxt_s.rb_s = s_ff.rb_m;
        nxt_s.rb_q = s_ff.rb_s;
        nxt_s.sb_m = select_button;
        nxt_s.sb_s = s_ff.sb_m;
        nxt_s.sb_q = s_ff.sb_s;
        nxt_s.hot_q = overheat;
        rst_press = s_ff.rb_s & ~s_ff.rb_q;
        sel_press = s_ff.sb_s & ~s_ff.sb_q;

        // Zero-wait slave: read data captured in the address phase
        take = hsel & htrans[1] & hready;
        wr_now = s_ff.a_valid & s_ff.a_wr;
        nxt_s.a_valid = take;
        nxt_s.a_wr = hwrite;
        nxt_s.a_addr = haddr[7:0];
        soft_wr = wr_now && s_ff.a_addr == `REG_CTRL && hwdata[`CTRL_SOFT_RST];
        if (wr_now) begin
            case (s_ff.a_addr)
                `REG_CTRL: nxt_s.stat_blink = hwdata[`CTRL_STAT_BLINK];
                `REG_BLINK: nxt_s.half = hwdata;
                `REG_IRQ_MASK: nxt_s.irq_mask = hwdata[`NUM_IRQ-1:0];
                `REG_MON: nxt_s.mon = hwdata[NPORTS-1:0];
                default: nxt_s.half = s_ff.half;
            endcase
        end

        // Blink divider; register value is cycles per half period
        tick = (s_ff.bcnt + 32'd1 >= s_ff.half); // [R12]
        if (tick) begin
            nxt_s.bcnt = 32'd0;
            nxt_s.blink = ~s_ff.blink; // [R12]
        end else begin
            nxt_s.bcnt = s_ff.bcnt + 32'd1;
        end

        ev = '0;
        nxt_s.restart = 1'b0;
        case (s_ff.st)
            ST_OFF: begin
                if (s_ff.pg_s) begin
                    nxt_s.st = ST_LAMP; // [R10]
                    nxt_s.cnt = 32'd0;
                end
            end
            ST_LAMP: begin
                nxt_s.cnt = s_ff.cnt + 32'd1;
                if (s_ff.cnt == 32'(LAMP_CYCLES - 1)) begin
                    nxt_s.st = ST_DIAG; // [R1]
                    nxt_s.cnt = 32'd0;
                end
            end
            ST_DIAG: begin
                // Saturate so the link flash cannot repeat on wrap
                if (s_ff.cnt != 32'hffffffff) begin
                    nxt_s.cnt = s_ff.cnt + 32'd1;
                end
                if (diag_fail) begin
                    nxt_s.st = ST_FAIL; // [R5]
                    nxt_s.cnt = 32'd0;
                    ev[`IRQ_FAIL] = 1'b1;
                end else if (diag_pass) begin
                    nxt_s.st = ST_RUN; // [R3]
                    ev[`IRQ_READY] = 1'b1;
                end
            end
            ST_RUN: begin
                nxt_s.cnt = 32'd0;
            end
            ST_FAIL: begin
                nxt_s.cnt = s_ff.cnt + 32'd1;
                if (s_ff.cnt == 32'(FAIL_CYCLES - 1)) begin
                    nxt_s.st = ST_LAMP; // [R5]
                    nxt_s.cnt = 32'd0;
                    nxt_s.restart = 1'b1;
                end
            end
            default: begin
                nxt_s.st = ST_LAMP;
                nxt_s.cnt = 32'd0;
            end
        endcase
        restart_evt = s_ff.st != ST_OFF && (rst_press | soft_wr | soft_reset_req | auto_reset_req);
        if (restart_evt) begin
            nxt_s.st = ST_LAMP; // [R10]
            nxt_s.cnt = 32'd0;
            nxt_s.restart = 1'b1;
        end
        if (!s_ff.pg_s) begin
            nxt_s.st = ST_OFF; // [R2]
            nxt_s.cnt = 32'd0;
        end

        if (sel_press && s_ff.st != ST_OFF) begin
            // Five selections, wrapping back to transmit
            if (s_ff.seg == SEG_USR) begin
                nxt_s.seg = SEG_TX; // [R8]
            end else begin
                nxt_s.seg = seg_e'(s_ff.seg + 3'd1); // [R8]
            end
            ev[`IRQ_SEL] = 1'b1;
        end
        ev[`IRQ_HOT] = overheat & ~s_ff.hot_q;

        case (s_ff.seg)
            SEG_TX: cond = tx_act; // [R9]
            SEG_RX: cond = rx_act; // [R9]
            SEG_ACT: cond = tx_act | rx_act; // [R9]
            SEG_COL: cond = collision; // [R9]
            SEG_USR: cond = rxtx_error; // [R9]
            default: cond = '0;
        endcase

        link_win = s_ff.cnt >= 32'(LINK_AT_CYCLES)
            && s_ff.cnt < 32'(LINK_AT_CYCLES + LINK_LEN_CYCLES);
        link_after = s_ff.cnt >= 32'(LINK_AT_CYCLES + LINK_LEN_CYCLES);

        nxt_s.pwr = s_ff.pg_s && s_ff.st != ST_OFF; // [R2]
        nxt_s.ready = 1'b0;
        nxt_s.link = '0;
        nxt_s.stat = '0;
        nxt_s.segl = '0;
        case (s_ff.st)
            ST_LAMP: begin
                nxt_s.ready = 1'b1; // [R1]
                nxt_s.stat = '1;
                nxt_s.segl = '1;
            end
            ST_DIAG: begin
                nxt_s.ready = s_ff.blink; // [R3]
                if (link_win) begin
                    nxt_s.link = '1; // [R4]
                end else if (link_after) begin
                    nxt_s.link = link_up; // [R4]
                end
                nxt_s.segl = `NUM_SEG'(1) << s_ff.seg;
            end
            ST_RUN: begin
                // Overheat keeps the diagnostic blink as a warning
                nxt_s.ready = overheat ? s_ff.blink : 1'b1; // [R3] [R11]
                nxt_s.link = link_up; // [R6]
                nxt_s.stat = cond & s_ff.mon
                    & (s_ff.stat_blink ? {NPORTS{s_ff.blink}} : {NPORTS{1'b1}}); // [R7]
                nxt_s.segl = `NUM_SEG'(1) << s_ff.seg; // [R8]
            end
            default: nxt_s.ready = 1'b0; // [R3] [R5]
        endcase

        // Read of status clears it; a same-cycle event still sets
        rd = 32'd0;
        clr = '0;
        case (haddr[7:0])
            `REG_CTRL: rd = {30'd0, 1'b0, s_ff.stat_blink};
            `REG_BLINK: rd = s_ff.half;
            `REG_IRQ_ST: rd = {28'd0, s_ff.irq_st};
            `REG_IRQ_MASK: rd = {28'd0, s_ff.irq_mask};
            `REG_STATE: rd = {21'd0, s_ff.pwr, overheat, s_ff.ready,
                1'b0, s_ff.seg, 1'b0, s_ff.st};
            `REG_MON: rd = 32'(s_ff.mon);
            default: rd = 32'd0;
        endcase
        if (take && !hwrite) begin
            nxt_s.rdata = rd;
            if (haddr[7:0] == `REG_IRQ_ST) begin
                clr = '1;
            end
        end
        nxt_s.irq_st = (s_ff.irq_st & ~clr) | ev;
        nxt_s.irq = |(nxt_s.irq_st & nxt_s.irq_mask);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '0;
            s_ff.st <= ST_LAMP;
            s_ff.seg <= SEG_TX;
            s_ff.half <= BLINK_HALF_DEF;
            s_ff.stat_blink <= `CTRL_RST_VAL;
            s_ff.mon <= '1;
            s_ff.irq_mask <= `IRQ_MASK_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    lamp_all_a: assert property (@(posedge clock) disable iff (!nrst) // [R1]
        s_ff.st == ST_LAMP |=> seg_led == '1 && link_led == '0 && ready_led)
        else $error("lamp phase indicators wrong");

    lamp_len_a: assert property (@(posedge clock) disable iff (!nrst) // [R1]
        $rose(s_ff.st == ST_DIAG) |-> $past(s_ff.cnt) == 32'(LAMP_CYCLES - 1)
            || $past(s_ff.st) != ST_LAMP)
        else $error("lamp phase length wrong");

    pwr_dark_a: assert property (@(posedge clock) disable iff (!nrst) // [R2]
        !s_ff.pg_s |=> !pwr_led ##1 !pwr_led || s_ff.pg_s)
        else $error("power led lit without power");

    diag_blink_a: assert property (@(posedge clock) disable iff (!nrst) // [R3]
        s_ff.st == ST_DIAG |=> ready_led == $past(s_ff.blink))
        else $error("ready not blinking in diagnostics");

    link_flash_a: assert property (@(posedge clock) disable iff (!nrst) // [R4]
        s_ff.st == ST_DIAG && link_win |=> link_led == '1)
        else $error("link flash missing");

    fail_reboot_a: assert property (@(posedge clock) disable iff (!nrst) // [R5]
        s_ff.st == ST_FAIL && s_ff.pg_s && !restart_evt
            |=> !ready_led && (s_ff.st == ST_FAIL || (s_ff.st == ST_LAMP && restart_pulse)))
        else $error("failure handling wrong");

    link_follow_a: assert property (@(posedge clock) disable iff (!nrst) // [R6]
        s_ff.st == ST_RUN |=> link_led == $past(link_up))
        else $error("link led not following link");

    status_map_a: assert property (@(posedge clock) disable iff (!nrst) // [R7]
        s_ff.st == ST_RUN && !s_ff.stat_blink |=> status_led == $past(cond & s_ff.mon))
        else $error("status led mapping wrong");

    seg_cycle_a: assert property (@(posedge clock) disable iff (!nrst) // [R8]
        sel_press && s_ff.st != ST_OFF && s_ff.seg == SEG_USR |=> s_ff.seg == SEG_TX)
        else $error("segment select does not wrap");

    seg_onehot_a: assert property (@(posedge clock) disable iff (!nrst) // [R8]
        s_ff.st == ST_RUN |=> $onehot(seg_led))
        else $error("segment leds not one-hot");

    act_either_a: assert property (@(posedge clock) disable iff (!nrst) // [R9]
        s_ff.st == ST_RUN && s_ff.seg == SEG_ACT && !s_ff.stat_blink |=> status_led ==
            $past((tx_act | rx_act) & s_ff.mon)) else $error("activity condition wrong");

    restart_seq_a: assert property (@(posedge clock) disable iff (!nrst) // [R10]
        restart_evt && s_ff.pg_s |=> s_ff.st == ST_LAMP && s_ff.cnt == 32'd0 && restart_pulse)
        else $error("restart did not rerun lamp sequence");

    hot_blink_a: assert property (@(posedge clock) disable iff (!nrst) // [R11]
        s_ff.st == ST_RUN && overheat |=> ready_led == $past(s_ff.blink))
        else $error("ready steady despite overheat");

    blink_div_a: assert property (@(posedge clock) disable iff (!nrst) // [R12]
        s_ff.blink != $past(s_ff.blink) |-> $past(s_ff.bcnt) + 32'd1 >= $past(s_ff.half))
        else $error("blink toggled before divider expired");
endmodule

// [test/front_panel_status_leds_tb_top.sv]
// Self-checking bench for the front-panel indicator controller.
// Assumes panel_defs.svh is on the include path and short sequence counts.
`timescale 1ns/1ps
`include "panel_defs.svh"

module front_panel_status_leds_tb_top;
    import panel_pkg::*;
    localparam int NP = 8;
    logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic power_good = 1, reset_button = 0, select_button = 0, soft_reset_req = 0;
    logic auto_reset_req = 0, diag_pass = 0, diag_fail = 0, overheat = 0;
    logic [NP-1:0] link_up = 0, tx_act = 0, rx_act = 0, collision = 0, rxtx_error = 0;
    logic pwr_led, ready_led, restart_pulse, irq;
    logic [NP-1:0] link_led, status_led, mon;
    logic [4:0] seg_led;
    logic [31:0] seed = 32'h9683;
    int n_mismatch = 0, cmp_count = 0, ones, zeros;

    // Short counts keep the whole run to a few hundred cycles
    front_panel_status_leds #(.NPORTS(NP), .LAMP_CYCLES(20), .LINK_AT_CYCLES(40),
        .LINK_LEN_CYCLES(10), .FAIL_CYCLES(15), .BLINK_HALF_DEF(32'h4)) dut_u (
        .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .power_good(power_good),
        .reset_button(reset_button), .select_button(select_button),
        .soft_reset_req(soft_reset_req), .auto_reset_req(auto_reset_req),
        .diag_pass(diag_pass), .diag_fail(diag_fail), .overheat(overheat),
        .link_up(link_up), .tx_act(tx_act), .rx_act(rx_act), .collision(collision),
        .rxtx_error(rxtx_error), .pwr_led(pwr_led), .ready_led(ready_led),
        .link_led(link_led), .status_led(status_led), .seg_led(seg_led),
        .restart_pulse(restart_pulse), .irq(irq));

    initial begin
        forever #25 clock = ~clock;
    end

    task tally_and_finish;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp, input string msg);
        chk_word({31'h0, got}, {31'h0, exp}, msg);
    endtask

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic [NP-1:0] cond_exp(input int s);
        case (s)
            0: return tx_act;
            1: return rx_act;
            2: return tx_act | rx_act;
            3: return collision;
            default: return rxtx_error;
        endcase
    endfunction

    function logic now_true(input int k);
        case (k)
            0: return seg_led === 5'h1f;
            1: return seg_led !== 5'h1f;
            2: return link_led === {NP{1'b1}};
            3: return link_led === link_up;
            default: return restart_pulse === 1'b1;
        endcase
    endfunction

    task wait_for(input int k, input int lim);
        int n;
        n = 0;
        #1;
        while (!now_true(k) && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            $display("mismatch at %0t: wait %0d ran out", $time, k);
            tally_and_finish();
        end
    endtask

    // Single AHB-Lite transfer; hreadyout doubles as the bus hready
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clock);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        n = 0;
        do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 20);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        chk_bit(hresp, 1'b0, "bus response");
        if (n >= 40) begin
            n_mismatch++;
            $display("mismatch at %0t: bus wait ran out", $time);
            tally_and_finish();
        end
    endtask

    task sample(input int k, input int len);
        ones = 0;
        zeros = 0;
        repeat (len) begin
            @(posedge clock);
            #1;
            if (k == 0 ? ready_led === 1'b1 : status_led === mon) ones++;
            if (k == 0 ? ready_led === 1'b0 : status_led === '0) zeros++;
        end
    endtask

    initial begin
        rd = rnd();
        link_up = {rd[NP-1:1], 1'b0};
        repeat (2) @(posedge clock);
        nrst <= 1;
        ahb(0, `REG_IRQ_MASK, 0);
        chk_word(rd, 32'h0, "mask reset");
        wait_for(0, 20);
        chk_bit(pwr_led, 1, "lamp pwr");
        chk_bit(ready_led, 1, "lamp ready");
        chk_word(32'(status_led), 32'hff, "lamp status");
        chk_word(32'(link_led), 0, "lamp link");
        wait_for(1, 40);
        chk_word(32'(seg_led), 32'h1, "diag seg");
        chk_word(32'(link_led), 0, "diag link early");
        chk_bit(pwr_led, 1, "diag pwr");
        sample(0, 16);
        chk_bit(ones > 0 && zeros > 0, 1, "diag ready blink");
        wait_for(2, 60);
        wait_for(3, 30);
        ahb(1, `REG_IRQ_MASK, 32'h1);
        @(posedge clock);
        diag_pass <= 1;
        @(posedge clock);
        diag_pass <= 0;
        sample(0, 10);
        chk_word(ones, 10, "run ready steady");
        chk_bit(irq, 1, "pass irq");
        ahb(0, `REG_IRQ_ST, 0);
        chk_word(rd, 32'h1, "irq status");
        ahb(0, `REG_STATE, 0);
        chk_word(rd & 32'h7, 32'h3, "run phase");
        chk_bit(irq, 0, "irq cleared");
        ahb(1, `REG_BLINK, 32'h3);
        ahb(0, `REG_BLINK, 0);
        chk_word(rd, 32'h3, "blink reg");
        ahb(0, 8'h3c, 0);
        chk_word(rd, 32'h0, "unmapped read");
        rd = rnd() | 32'h1;
        mon = rd[NP-1:0];
        ahb(1, `REG_MON, rd);
        ahb(0, `REG_MON, 0);
        chk_word(32'(rd[NP-1:0]), 32'(mon), "mon reg");
        for (int s = 0; s < 5; s++) begin
            @(posedge clock);
            rd = rnd();
            tx_act <= rd[7:0];
            rx_act <= rd[15:8];
            collision <= rd[23:16];
            rxtx_error <= rd[31:24];
            repeat (3) @(posedge clock);
            #1;
            chk_word(32'(seg_led), 32'h1 << s, "segment led");
            chk_word(32'(status_led), 32'(cond_exp(s) & mon), "status led");
            @(posedge clock);
            select_button <= 1;
            repeat (4) @(posedge clock);
            select_button <= 0;
            repeat (4) @(posedge clock);
        end
        #1;
        chk_word(32'(seg_led), 32'h1, "segment wrap");
        chk_bit(irq, 0, "masked select");
        ahb(0, `REG_IRQ_ST, 0);
        chk_word(rd, 32'h8, "select status");
        tx_act <= '1;
        ahb(1, `REG_CTRL, 32'h1);
        sample(1, 16);
        chk_bit(ones > 0 && zeros > 0, 1, "status blink");
        @(posedge clock);
        overheat <= 1;
        sample(0, 16);
        chk_bit(ones > 0 && zeros > 0, 1, "hot ready blink");
        @(posedge clock);
        overheat <= 0;
        ahb(0, `REG_IRQ_ST, 0);
        chk_word(rd, 32'h4, "hot status");
        ahb(1, `REG_CTRL, 32'h0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            case (k)
                0: reset_button <= 1;
                1: soft_reset_req <= 1;
                2: auto_reset_req <= 1;
                default: ahb(1, `REG_CTRL, 32'h2);
            endcase
            if (k == 1 || k == 2) begin
                @(posedge clock);
                soft_reset_req <= 0;
                auto_reset_req <= 0;
            end
            wait_for(4, 12);
            wait_for(0, 5);
            @(posedge clock);
            reset_button <= 0;
        end
        wait_for(1, 40);
        @(posedge clock);
        diag_fail <= 1;
        @(posedge clock);
        diag_fail <= 0;
        sample(0, 8);
        chk_word(zeros, 8, "fail ready dark");
        wait_for(4, 30);
        ahb(0, `REG_IRQ_ST, 0);
        chk_word(rd, 32'h2, "fail status");
        @(posedge clock);
        power_good <= 0;
        repeat (5) @(posedge clock);
        #1;
        chk_bit(pwr_led, 0, "no power");
        chk_bit(ready_led, 0, "no power ready");
        tally_and_finish();
    end
endmodule
